// *** core/vio_consts.vh ***
// Constants for the virtual I/O routing block: register map, fields, timing.
// Assumes a 50 MHz pclk and a 32-bit APB register bus.
`ifndef VIO_CONSTS_VH
`define VIO_CONSTS_VH

// Register byte offsets
`define OFF_VIN_SRC_MODE      12'h000
`define OFF_VIN_FORCED        12'h004
`define OFF_ANA_POLARITY      12'h008
`define OFF_VOUT_POLARITY     12'h00c
`define OFF_VIN_FUNC0         12'h010
`define OFF_ANA_FUNC0         12'h024
`define OFF_VOUT_FUNC0        12'h02c
`define OFF_VOUT_DELAY0       12'h040
`define OFF_STATUS            12'h054
`define OFF_CONTROL           12'h058

// Field widths and ranges
`define FUNC_W                6
`define VIN_FUNC_MAX          6'h3b
`define VOUT_FUNC_MAX         6'h28
`define DELAY_W               16
`define DELAY_MAX             16'h8ca0
`define ANA_POL_BITS          2

// Reset values
`define RST_DIGITS            16'h0000
`define RST_FUNC              6'h00
`define RST_DELAY             16'h0000

// Analog thresholds, millivolts
`define ANA_HIGH_MV           16'h1b58
`define ANA_LOW_MV            16'h0bb8

// Delay tick: 0.1 s at 50 MHz
`define TICK_NS               100000000
`define CLK_NS                20
`define TICK_CYCLES           (`TICK_NS / `CLK_NS)

`endif

// *** core/vout_delay.v ***
// One virtual output delay stage: function state delayed on both edges.
// Assumes a one-cycle 0.1 s tick enable from the parent.
`default_nettype none

module vout_delay #(
   parameter DW = 16
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          tick,
   input  wire          din,
   input  wire [DW-1:0] delay,
   output reg           dout
);

   reg [DW-1:0] cnt_q;

   // Any change of input restarts the count, so short glitches are filtered
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= {DW{1'b0}};
         dout  <= 1'b0;
      end
      else if (din == dout)
         cnt_q <= {DW{1'b0}};
      else if (delay == {DW{1'b0}})
         dout <= din;
      else if (tick)
      begin
         if (cnt_q + 1'b1 >= delay)
         begin
            dout  <= din;
            cnt_q <= {DW{1'b0}};
         end
         else
            cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule // vout_delay

`default_nettype wire

// *** core/virtual_io_routing.v ***
// Virtual input/output routing with APB registers.
// Assumes synchronous inputs, digitised analog levels in millivolts and
// a status function vector supplied by the drive's output logic.
// How it works
// - Five virtual inputs each hold a function code 0-59, reset 0.
// - Bit x of the source mode picks output x (0) or forced state (1).
// - In output mode virtual input x follows only virtual output x.
// - In forced mode bit x of the forced state is the input's level.
// - After reset release the inputs are presented to terminal logic.
// - Two analog channels each hold a function code 0-59, reset 0.
// - Analog reads high at 7 V or more, low at 3 V or less, else holds.
// - Polarity bit per analog channel, 1 means low level is active.
// - Output function 0 mirrors physical input x, 1-40 pick a status.
// - Polarity bit per output, 1 inverts it.
`default_nettype none
`include "vio_consts.vh"

module virtual_io_routing #(
   parameter NV         = 5,
   parameter NA         = 2,
   parameter TICK_COUNT = `TICK_CYCLES
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire [NV-1:0]     phys_input,
   input  wire [40:1]       status_func,
   input  wire [15:0]       analog1_mv,
   input  wire [15:0]       analog2_mv,
   output reg  [NV-1:0]     virtual_input,
   output reg  [NV*6-1:0]   virtual_input_function,
   output reg  [NA-1:0]     analog_input,
   output reg  [NA*6-1:0]   analog_input_function,
   output reg  [NV-1:0]     virtual_output,
   output reg               inputs_active
);

   // Registers
   reg [15:0]         vin_src_q;
   reg [15:0]         vin_forced_q;
   reg [15:0]         ana_pol_q;
   reg [15:0]         vout_pol_q;
   reg [5:0]          vin_func_q  [0:NV-1];
   reg [5:0]          ana_func_q  [0:NA-1];
   reg [5:0]          vout_func_q [0:NV-1];
   reg [15:0]         vout_dly_q  [0:NV-1];
   reg [NA-1:0]       ana_level_q;
   reg [31:0]         tick_cnt_q;
   reg                tick_q;
   reg                init_q;

   wire [NV-1:0]      vout_state;
   wire [NV-1:0]      vout_delayed;
   wire [NV-1:0]      vout_final;
   wire               wr_en;
   wire               rd_en;
   wire               known;

   // Zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign known   = addr_known(paddr);
   assign pslverr = psel && penable && !known;

   function addr_known;
      input [11:0] a;
      begin
         addr_known = (a[1:0] == 2'b00) && (a <= `OFF_CONTROL);
      end
   endfunction

   // Out-of-range function codes are clamped to the top of the range
   function [5:0] clamp;
      input [5:0] v;
      input [5:0] mx;
      begin
         clamp = (v > mx) ? mx : v;
      end
   endfunction

   // Delays above the top of the range are clamped to it
   function [15:0] clamp_delay;
      input [15:0] v;
      begin
         clamp_delay = (v > `DELAY_MAX) ? `DELAY_MAX : v;
      end
   endfunction

   // Hit on entry idx of a table of word registers starting at base
   function slot_hit;
      input [11:0] a;
      input [11:0] base;
      input [2:0]  idx;
      begin
         slot_hit = (a == base + {idx, 2'b00});
      end
   endfunction

   // Register writes
   integer i;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vin_src_q    <= `RST_DIGITS;
         vin_forced_q <= `RST_DIGITS;
         ana_pol_q    <= `RST_DIGITS;
         vout_pol_q   <= `RST_DIGITS;
         for (i = 0; i < NV; i = i + 1)
         begin
            vin_func_q[i]  <= `RST_FUNC;
            vout_func_q[i] <= `RST_FUNC;
            vout_dly_q[i]  <= `RST_DELAY;
         end
         for (i = 0; i < NA; i = i + 1)
            ana_func_q[i] <= `RST_FUNC;
      end
      else if (wr_en)
      begin
         case (paddr)
            `OFF_VIN_SRC_MODE:  vin_src_q    <= pwdata[15:0];
            `OFF_VIN_FORCED:    vin_forced_q <= pwdata[15:0];
            `OFF_ANA_POLARITY:  ana_pol_q    <= pwdata[15:0];
            `OFF_VOUT_POLARITY: vout_pol_q   <= pwdata[15:0];
            default:
            begin
               for (i = 0; i < NV; i = i + 1)
               begin
                  if (slot_hit(paddr, `OFF_VIN_FUNC0, i[2:0]))
                     vin_func_q[i] <= clamp(pwdata[5:0],
                                            `VIN_FUNC_MAX);
                  if (slot_hit(paddr, `OFF_VOUT_FUNC0, i[2:0]))
                     vout_func_q[i] <= clamp(pwdata[5:0],
                                             `VOUT_FUNC_MAX);
                  if (slot_hit(paddr, `OFF_VOUT_DELAY0, i[2:0]))
                     vout_dly_q[i] <= clamp_delay(pwdata[15:0]);
               end
               for (i = 0; i < NA; i = i + 1)
                  if (slot_hit(paddr, `OFF_ANA_FUNC0, i[2:0]))
                     ana_func_q[i] <= clamp(pwdata[5:0],
                                            `VIN_FUNC_MAX);
            end
         endcase
      end
   end

   // Status word: [4:0] inputs, [9:5] outputs, [11:10] analog inputs,
   // [13:12] zero, [15:14] raw analog levels; init done sits in CONTROL
   wire [15:0] status_word;
   assign status_word = {ana_level_q[1:0],
                         2'b00,
                         analog_input[1:0],
                         virtual_output[4:0],
                         virtual_input[4:0]};

   // Register reads
   integer j;
   always @*
   begin
      prdata = 32'h0000_0000;
      if (rd_en)
      begin
         case (paddr)
            `OFF_VIN_SRC_MODE:  prdata = {16'h0000, vin_src_q};
            `OFF_VIN_FORCED:    prdata = {16'h0000, vin_forced_q};
            `OFF_ANA_POLARITY:  prdata = {16'h0000, ana_pol_q};
            `OFF_VOUT_POLARITY: prdata = {16'h0000, vout_pol_q};
            `OFF_STATUS:        prdata = {16'h0000, status_word};
            `OFF_CONTROL:       prdata = {31'h0, init_q};
            default:
            begin
               for (j = 0; j < NV; j = j + 1)
               begin
                  if (slot_hit(paddr, `OFF_VIN_FUNC0, j[2:0]))
                     prdata = {26'h0, vin_func_q[j]};
                  if (slot_hit(paddr, `OFF_VOUT_FUNC0, j[2:0]))
                     prdata = {26'h0, vout_func_q[j]};
                  if (slot_hit(paddr, `OFF_VOUT_DELAY0, j[2:0]))
                     prdata = {16'h0, vout_dly_q[j]};
               end
               for (j = 0; j < NA; j = j + 1)
                  if (slot_hit(paddr, `OFF_ANA_FUNC0, j[2:0]))
                     prdata = {26'h0, ana_func_q[j]};
            end
         endcase
      end
   end

   // 0.1 s tick divider for the output delays
   // Free running, so the first tick of a delay may come up to a tick early
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b0;
      end
      else if (tick_cnt_q >= TICK_COUNT - 1)
      begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         tick_q     <= 1'b0;
      end
   end

   // Virtual outputs: select, delay, then invert
   genvar g;
   generate
      for (g = 0; g < NV; g = g + 1)
      begin : g_vout
         assign vout_state[g] = (vout_func_q[g] == 6'h00) ?
                                phys_input[g] :
                                status_func[vout_func_q[g]];

         vout_delay #(
            .DW      (`DELAY_W)
         ) u_dly (
            .pclk    (pclk),
            .presetn (presetn),
            .tick    (tick_q),
            .din     (vout_state[g]),
            .delay   (vout_dly_q[g]),
            .dout    (vout_delayed[g])
         );

         assign vout_final[g] = vout_delayed[g] ^ vout_pol_q[g];
      end
   endgenerate

   // Analog levels with hysteresis; only the low polarity bits are used
   wire [15:0] ana_mv [0:1];
   assign ana_mv[0] = analog1_mv;
   assign ana_mv[1] = analog2_mv;
   integer k;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ana_level_q <= {NA{1'b0}};
      else
         for (k = 0; k < NA; k = k + 1)
         begin
            if (ana_mv[k] >= `ANA_HIGH_MV)
               ana_level_q[k] <= 1'b1;
            else if (ana_mv[k] <= `ANA_LOW_MV)
               ana_level_q[k] <= 1'b0;
         end
   end

   // Outputs registered; inputs are withheld until reset init completes
   integer m;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_q                 <= 1'b0;
         virtual_input          <= {NV{1'b0}};
         virtual_output         <= {NV{1'b0}};
         analog_input           <= {NA{1'b0}};
         virtual_input_function <= {NV*6{1'b0}};
         analog_input_function  <= {NA*6{1'b0}};
         inputs_active          <= 1'b0;
      end
      else
      begin
         init_q         <= 1'b1;
         inputs_active  <= init_q;
         virtual_output <= vout_final;
         for (m = 0; m < NV; m = m + 1)
         begin
            virtual_input[m] <= init_q &&
               (vin_src_q[m] ? vin_forced_q[m] :
                               vout_final[m]);
            virtual_input_function[m*6 +: 6] <= vin_func_q[m];
         end
         for (m = 0; m < NA; m = m + 1)
         begin
            analog_input[m] <= init_q &&
               (ana_level_q[m] ^ ana_pol_q[m]);
            analog_input_function[m*6 +: 6] <= ana_func_q[m];
         end
      end
   end

endmodule // virtual_io_routing

`default_nettype wire

// *** verif/vio_properties.sv ***
// Port relations of the virtual I/O routing block.
// Bound to the top module; one clock domain, async active-low reset.
`default_nettype none
module vio_properties #(
   parameter NV = 5,
   parameter NA = 2
) (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [31:0]     prdata,
   input wire logic            pslverr,
   input wire logic [15:0]     analog1_mv,
   input wire logic [NV-1:0]   virtual_input,
   input wire logic [NV*6-1:0] virtual_input_function,
   input wire logic [NA-1:0]   analog_input,
   input wire logic [NA*6-1:0] analog_input_function,
   input wire logic            inputs_active
);
   timeunit 1ns;
   timeprecision 1ps;
   wire wr   = psel && penable && pwrite;
   wire band = analog1_mv > 16'h0bb8 && analog1_mv < 16'h1b58;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   rdata_idle_a: assert property (!(psel && penable && !pwrite)
      |-> prdata == 32'h0) else $error("prdata nonzero when idle");
   for (genvar i = 0; i < NV; i++)
   begin : g_vin
      vin_range_a: assert property (
         virtual_input_function[i*6 +: 6] <= 6'h3b)
         else $error("input function above range");
   end
   for (genvar j = 0; j < NA; j++)
   begin : g_ana
      ana_range_a: assert property (
         analog_input_function[j*6 +: 6] <= 6'h3b)
         else $error("analog function above range");
   end
   // All writes are excluded: a polarity write may flip the level legally
   band_hold_a: assert property (band && !wr ##1 !wr
      |=> $stable(analog_input[0])) else $error("analog moved in band");
   active_late_a: assert property (inputs_active
      |-> $past(presetn, 2)) else $error("inputs active too early");
   quiet_inputs_a: assert property (!inputs_active
      |-> virtual_input == 0 && analog_input == 0)
      else $error("inputs valid before init");
   active_hold_a: assert property (inputs_active |=> inputs_active)
      else $error("inputs_active dropped");
endmodule // vio_properties
`default_nettype wire

// *** verif/drive_terminals.sv ***
// Drive-side model: terminals, status functions, analog levels, run.
// The bench sets the *_d levels; they reach the block at a rising edge.
`default_nettype none
module drive_terminals #(
   parameter logic [5:0] RUN_CODE = 6'h01
) (
   input  wire logic        pclk,
   input  wire logic [4:0]  virtual_input,
   input  wire logic [29:0] virtual_input_function,
   input  wire logic        inputs_active,
   output var  logic [4:0]  phys_input,
   output var  logic [40:1] status_func,
   output var  logic [15:0] analog1_mv,
   output var  logic [15:0] analog2_mv,
   output var  logic        run_fwd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0]  phys_d = 5'h00;
   logic [40:1] status_d = 40'h0;
   logic [15:0] a1_d = 16'h0000;
   logic [15:0] a2_d = 16'h0000;
   initial
   begin
      phys_input = 5'h00;
      status_func = 40'h0;
      analog1_mv = 16'h0000;
      analog2_mv = 16'h0000;
      run_fwd = 1'b0;
   end
   // A valid run function acts exactly as a physical run pin would
   always @(posedge pclk)
   begin
      phys_input  <= phys_d;
      status_func <= status_d;
      analog1_mv  <= a1_d;
      analog2_mv  <= a2_d;
      run_fwd     <= 1'b0;
      for (int i = 0; i < 5; i++)
         if (inputs_active && virtual_input[i]
             && virtual_input_function[i*6 +: 6] == RUN_CODE)
            run_fwd <= 1'b1;
   end
endmodule // drive_terminals
`default_nettype wire

// *** verif/virtual_io_routing_tb.sv ***
// Self-checking bench: APB register tasks and datapath scenarios.
// Short delay tick so the delay stages settle within tens of cycles.
`default_nettype none
module virtual_io_routing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [40:1] m;
   wire  [31:0] prdata;
   wire         pready, pslverr, inputs_active, run_fwd;
   wire  [4:0]  phys_input, virtual_input, virtual_output;
   wire  [40:1] status_func;
   wire  [15:0] analog1_mv, analog2_mv;
   wire  [29:0] vin_func;
   wire  [11:0] ana_func;
   wire  [1:0]  analog_input;
   int          err_count = 0;
   int          num_checks = 0;
   logic [15:0] av [4] = '{16'h1b58, 16'h1388, 16'h0bb8, 16'h1388};
   virtual_io_routing #(.TICK_COUNT(10)) virtual_io_routing_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phys_input(phys_input),
      .status_func(status_func), .analog1_mv(analog1_mv),
      .analog2_mv(analog2_mv), .virtual_input(virtual_input),
      .virtual_input_function(vin_func), .analog_input(analog_input),
      .analog_input_function(ana_func), .virtual_output(virtual_output),
      .inputs_active(inputs_active));
   drive_terminals drv (.pclk(pclk), .virtual_input(virtual_input),
      .virtual_input_function(vin_func), .inputs_active(inputs_active),
      .phys_input(phys_input), .status_func(status_func),
      .analog1_mv(analog1_mv), .analog2_mv(analog2_mv), .run_fwd(run_fwd));
   always #10 pclk = ~pclk;
   task automatic chk(input string n, input logic [39:0] s, e);
      num_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] x);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      chk("pready", pready, 1'b1);
      chk("apb", {pslverr, w ? 32'h0 : prdata}, x);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic w8(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 'h50; a += 4)
         acc(1'b0, a[11:0], 32'h0, 33'h0);
      acc(1'b0, 12'h058, 32'h0, 33'h1);
      chk("active", inputs_active, 1'b1);
      acc(1'b0, 12'h05c, 32'h0, {1'b1, 32'h0});
      acc(1'b1, 12'h002, 32'h1, {1'b1, 32'h0});
      acc(1'b1, 12'h010, 32'h3c, 33'h0);
      acc(1'b0, 12'h010, 32'h0, 33'h3b);
      acc(1'b1, 12'h028, 32'h3f, 33'h0);
      acc(1'b0, 12'h028, 32'h0, 33'h3b);
      acc(1'b1, 12'h02c, 32'h29, 33'h0);
      acc(1'b0, 12'h02c, 32'h0, 33'h28);
      chk("ana_func", ana_func[11:6], 6'h3b);
      $display("end registers");
      acc(1'b1, 12'h010, 32'h1, 33'h0);
      acc(1'b1, 12'h000, 32'h1f, 33'h0);
      acc(1'b1, 12'h004, 32'h15, 33'h0);
      w8(2);
      chk("vin", virtual_input, 5'h15);
      chk("run", run_fwd, 1'b1);
      acc(1'b1, 12'h004, 32'h0a, 33'h0);
      w8(2);
      chk("vin", virtual_input, 5'h0a);
      chk("run", run_fwd, 1'b0);
      $display("end forced");
      acc(1'b1, 12'h02c, 32'h0, 33'h0);
      acc(1'b1, 12'h000, 32'h0, 33'h0);
      acc(1'b1, 12'h00c, 32'h3, 33'h0);
      drv.phys_d <= 5'h05;
      w8(5);
      chk("vout", virtual_output, 5'h06);
      chk("vin", virtual_input, 5'h06);
      acc(1'b1, 12'h00c, 32'h0, 33'h0);
      for (int c = 1; c <= 40; c++)
      begin
         acc(1'b1, 12'h030, 32'(c), 33'h0);
         m = 40'h1 << (c - 1);
         drv.status_d <= m;
         w8(4);
         chk("vout2", virtual_output[1], 1'b1);
         drv.status_d = ~m;
         w8(4);
         chk("vout2", virtual_output[1], 1'b0);
      end
      $display("end mirror and status");
      acc(1'b1, 12'h048, 32'h3, 33'h0);
      // Second pass inverts first: the delay must act before inversion
      for (int k = 0; k < 2; k++)
      begin
         acc(1'b1, 12'h00c, 32'(k * 4), 33'h0);
         drv.phys_d <= k ? 5'h05 : 5'h01;
         w8(12);
         chk("vout3", virtual_output[2], 1'b1);
         w8(30);
         chk("vout3", virtual_output[2], 1'b0);
      end
      $display("end delay");
      foreach (av[i])
      begin
         drv.a1_d = av[i];
         w8(4);
         chk("ana", analog_input, {1'b0, i < 2});
      end
      acc(1'b1, 12'h008, 32'h5, 33'h0);
      w8(2);
      chk("ana", analog_input, 2'b01);
      drv.a2_d = 16'h1b58;
      w8(4);
      chk("ana", analog_input, 2'b11);
      acc(1'b0, 12'h054, 32'h0, 33'h8c21);
      $display("end analog");
      summarize();
   end
   initial
   begin
      repeat (5000) @(posedge pclk);
      err_count++;
      summarize();
   end
endmodule // virtual_io_routing_tb
bind virtual_io_routing vio_properties #(.NV(NV), .NA(NA)) vio_properties_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
   .analog1_mv(analog1_mv), .virtual_input(virtual_input),
   .virtual_input_function(virtual_input_function),
   .analog_input(analog_input), .inputs_active(inputs_active),
   .analog_input_function(analog_input_function));
`default_nettype wire
